// *** bfd_pkg.sv ***
// constants and carrier types for the burst fifo data window
package bfd_pkg;

  localparam int NUM_CH = 8;
  localparam int DEPTH  = 64;
  localparam int PTR_W  = 6;
  localparam int CNT_W  = 7;
  localparam int ADDR_W = 12;
  localparam int LANES  = 4;

  // address fields: channel in the top bits, window select below
  localparam int CH_LSB      = 9;
  localparam int WIN_SEL_BIT = 8;  // set for the burst windows at 0xM00 with M odd
  localparam int STAT_BIT    = 7;  // set for 0xM80..0xMFF
  localparam int PLAIN_HI    = 6;  // must be clear for 0xM00..0xM3F
  localparam int DW_LSB      = 2;  // requests carry dword addresses, lanes by enable

  // byte enable pattern allowed at the legacy holding registers
  localparam logic [LANES-1:0] LEGACY_BE = 4'h1;

  localparam logic [CNT_W-1:0] CNT_FULL = 7'h40;
  localparam logic [PTR_W-1:0] PTR_ONE  = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ONE  = 7'h01;

  typedef enum logic [1:0] {
    WIN_RSVD,
    WIN_LEGACY,
    WIN_PLAIN,
    WIN_STAT
  } bfd_win_t;

  // host request, taken in the cycle that valid is high
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  be;
    logic [31:0]       wdata;
  } bfd_req_t;

  // answer, one cycle after each request
  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] rdata;
  } bfd_rsp_t;

  // receive byte from a channel's receiver, with its line status byte
  typedef struct packed {
    logic       push;
    logic [7:0] line_status_byte;
    logic [7:0] data;
  } bfd_rx_in_t;

  // transmit byte handed to a channel's transmitter
  typedef struct packed {
    logic       vld;
    logic [7:0] data;
  } bfd_tx_out_t;

  typedef struct packed {
    logic [NUM_CH-1:0][DEPTH-1:0][15:0] rx_mem;  // {line status, data}
    logic [NUM_CH-1:0][DEPTH-1:0][7:0]  tx_mem;
    logic [NUM_CH-1:0][PTR_W-1:0]       rx_rd;
    logic [NUM_CH-1:0][PTR_W-1:0]       rx_wr;
    logic [NUM_CH-1:0][PTR_W-1:0]       tx_rd;
    logic [NUM_CH-1:0][PTR_W-1:0]       tx_wr;
    logic [NUM_CH-1:0][CNT_W-1:0]       rx_cnt;
    logic [NUM_CH-1:0][CNT_W-1:0]       tx_cnt;
    bfd_rsp_t                           rsp;
    bfd_tx_out_t [NUM_CH-1:0]           tx_out;
  } bfd_state_t;

  localparam bfd_state_t STATE_RST = '0;

endpackage : bfd_pkg

// *** bfd_data_window.sv ***
// burst fifo data window: host byte, burst and status access to eight channel fifos
// Functional notes
// - channel N burst window at hundreds digit 2N+1
// - 0xM00-0xM3F reads pop rx, writes push tx
// - 0xM80-0xMFF returns rx data with status
// - whole rx fifo drains in 16 dword reads
// - status byte pops together with its data byte
// - rx fifo with status drains in 32 dwords
// - burst reads and writes move up to 64 bytes
// - bursts accepted at 0xM00-0xM3F, and as reads only at 0xM80-0xMFF
// - configuration data access takes 8 to 32 bits
// - legacy holding registers only take byte access
// - legacy rx holding register at N times 0x200
`timescale 1ns/1ps
module bfd_data_window
  import bfd_pkg::*;
(
  input  wire logic                                    clock,
  input  wire logic                                    rst_n,
  input  wire bfd_pkg::bfd_req_t                       host_req,
  output bfd_pkg::bfd_rsp_t                            host_rsp,
  input  wire bfd_pkg::bfd_rx_in_t [bfd_pkg::NUM_CH-1:0] rx_in,
  input  wire logic [bfd_pkg::NUM_CH-1:0]              tx_pop_req,
  output bfd_pkg::bfd_tx_out_t [bfd_pkg::NUM_CH-1:0]   tx_out,
  output logic [bfd_pkg::NUM_CH-1:0][bfd_pkg::CNT_W-1:0] rx_level,
  output logic [bfd_pkg::NUM_CH-1:0][bfd_pkg::CNT_W-1:0] tx_level
);
  import bfd_pkg::*;

  bfd_state_t        st_ff;
  bfd_state_t        nxt_st;
  logic [2:0]        req_ch;
  bfd_win_t          req_kind;
  logic [CNT_W-1:0]  cur_rx_cnt;
  logic [CNT_W-1:0]  cur_tx_cnt;
  logic [15:0]       cur_rx_head;
  logic [15:0]       cur_rx_next;
  logic              cur_rx_push;
  logic              cur_tx_pop;

  // window decode, shared by the datapath and the checks below
  function automatic bfd_win_t bfd_win(input logic [ADDR_W-1:0] a);
    bfd_win_t w;
    w = WIN_RSVD;
    if (!a[WIN_SEL_BIT]) begin
      if (a[WIN_SEL_BIT-1:DW_LSB] == '0) begin
        w = WIN_LEGACY;
      end
    end else if (a[STAT_BIT]) begin
      w = WIN_STAT;
    end else if (!a[PLAIN_HI]) begin
      w = WIN_PLAIN;
    end
    return w;
  endfunction : bfd_win

  // channel select and the current fifo view, used by the checks
  assign req_ch      = host_req.addr[ADDR_W-1:CH_LSB];
  assign req_kind    = bfd_win(host_req.addr);
  assign cur_rx_cnt  = st_ff.rx_cnt[req_ch];
  assign cur_tx_cnt  = st_ff.tx_cnt[req_ch];
  assign cur_rx_head = st_ff.rx_mem[req_ch][st_ff.rx_rd[req_ch]];
  assign cur_rx_next = st_ff.rx_mem[req_ch][st_ff.rx_rd[req_ch] + PTR_ONE];
  assign cur_rx_push = rx_in[req_ch].push;
  assign cur_tx_pop  = tx_pop_req[req_ch];

  // host access first, then channel side; each works on the updated copy so
  // a push and a pop in one cycle on one fifo both count
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.rsp = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      nxt_st.tx_out[c] = '0;
    end
    if (host_req.valid) begin
      nxt_st.rsp.valid = 1'b1;
      case (req_kind)
        WIN_PLAIN: begin
          // lanes in ascending order so lane 0 gets the oldest byte
          for (int ln = 0; ln < LANES; ln++) begin
            if (host_req.be[ln]) begin
              if (host_req.write) begin
                if (nxt_st.tx_cnt[req_ch] < CNT_FULL) begin
                  nxt_st.tx_mem[req_ch][nxt_st.tx_wr[req_ch]] = host_req.wdata[8*ln +: 8];
                  nxt_st.tx_wr[req_ch]  = nxt_st.tx_wr[req_ch] + PTR_ONE;
                  nxt_st.tx_cnt[req_ch] = nxt_st.tx_cnt[req_ch] + CNT_ONE;
                end
              end else if (nxt_st.rx_cnt[req_ch] != '0) begin
                nxt_st.rsp.rdata[8*ln +: 8] =
                  nxt_st.rx_mem[req_ch][nxt_st.rx_rd[req_ch]][7:0];
                nxt_st.rx_rd[req_ch]  = nxt_st.rx_rd[req_ch] + PTR_ONE;
                nxt_st.rx_cnt[req_ch] = nxt_st.rx_cnt[req_ch] - CNT_ONE;
              end
            end
          end
        end
        WIN_STAT: begin
          if (host_req.write) begin
            nxt_st.rsp.err = 1'b1;  // read-only window
          end else begin
            // one entry per half; a half touched at all pops the whole pair
            for (int h = 0; h < 2; h++) begin
              if ((|host_req.be[2*h +: 2]) && (nxt_st.rx_cnt[req_ch] != '0)) begin
                nxt_st.rsp.rdata[16*h +: 16] = {
                  nxt_st.rx_mem[req_ch][nxt_st.rx_rd[req_ch]][7:0],
                  nxt_st.rx_mem[req_ch][nxt_st.rx_rd[req_ch]][15:8]};
                nxt_st.rx_rd[req_ch]  = nxt_st.rx_rd[req_ch] + PTR_ONE;
                nxt_st.rx_cnt[req_ch] = nxt_st.rx_cnt[req_ch] - CNT_ONE;
              end
            end
          end
        end
        WIN_LEGACY: begin
          if (host_req.be != LEGACY_BE) begin
            nxt_st.rsp.err = 1'b1;
          end else if (host_req.write) begin
            if (nxt_st.tx_cnt[req_ch] < CNT_FULL) begin
              nxt_st.tx_mem[req_ch][nxt_st.tx_wr[req_ch]] = host_req.wdata[7:0];
              nxt_st.tx_wr[req_ch]  = nxt_st.tx_wr[req_ch] + PTR_ONE;
              nxt_st.tx_cnt[req_ch] = nxt_st.tx_cnt[req_ch] + CNT_ONE;
            end
          end else if (nxt_st.rx_cnt[req_ch] != '0) begin
            nxt_st.rsp.rdata[7:0] = nxt_st.rx_mem[req_ch][nxt_st.rx_rd[req_ch]][7:0];
            nxt_st.rx_rd[req_ch]  = nxt_st.rx_rd[req_ch] + PTR_ONE;
            nxt_st.rx_cnt[req_ch] = nxt_st.rx_cnt[req_ch] - CNT_ONE;
          end
        end
        default: begin
          nxt_st.rsp.err = 1'b1;
        end
      endcase
    end
    // channel side: receiver pushes, transmitter pulls; overflow drops the byte
    for (int c = 0; c < NUM_CH; c++) begin
      if (rx_in[c].push && (nxt_st.rx_cnt[c] < CNT_FULL)) begin
        nxt_st.rx_mem[c][nxt_st.rx_wr[c]] = {rx_in[c].line_status_byte, rx_in[c].data};
        nxt_st.rx_wr[c]  = nxt_st.rx_wr[c] + PTR_ONE;
        nxt_st.rx_cnt[c] = nxt_st.rx_cnt[c] + CNT_ONE;
      end
      if (tx_pop_req[c] && (nxt_st.tx_cnt[c] != '0)) begin
        nxt_st.tx_out[c].vld  = 1'b1;
        nxt_st.tx_out[c].data = nxt_st.tx_mem[c][nxt_st.tx_rd[c]];
        nxt_st.tx_rd[c]  = nxt_st.tx_rd[c] + PTR_ONE;
        nxt_st.tx_cnt[c] = nxt_st.tx_cnt[c] - CNT_ONE;
      end
    end
  end

  // the one state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_ff <= STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign host_rsp = st_ff.rsp;
  assign tx_out   = st_ff.tx_out;
  assign rx_level = st_ff.rx_cnt;
  assign tx_level = st_ff.tx_cnt;

  // every request gets exactly one answer the next cycle
  property p_answer;
    @(posedge clock) disable iff (!rst_n)
      host_req.valid |=> host_rsp.valid;
  endproperty
  a_answer: assert property (p_answer) else $error("request without answer");

  // reserved addresses refuse and leave the rx fifo alone
  property p_reserved;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && req_kind == WIN_RSVD && !cur_rx_push && !cur_tx_pop)
      |=> host_rsp.err && st_ff.rx_cnt[$past(req_ch)] == $past(cur_rx_cnt);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved access not refused");

  // legacy holding registers refuse anything but a single low byte
  property p_legacy_width;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && req_kind == WIN_LEGACY && host_req.be != LEGACY_BE)
      |=> host_rsp.err;
  endproperty
  a_legacy_width: assert property (p_legacy_width) else $error("wide legacy access taken");

  // a full dword read of the plain window pops four bytes
  property p_plain_pop4;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && !host_req.write && req_kind == WIN_PLAIN && host_req.be == 4'hf
       && cur_rx_cnt >= 7'h04 && !cur_rx_push)
      |=> st_ff.rx_cnt[$past(req_ch)] == $past(cur_rx_cnt) - 7'h04;
  endproperty
  a_plain_pop4: assert property (p_plain_pop4) else $error("plain read did not pop four");

  // a full dword read of the status window pops two entries
  property p_stat_pop2;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && !host_req.write && req_kind == WIN_STAT && host_req.be == 4'hf
       && cur_rx_cnt >= 7'h02 && !cur_rx_push)
      |=> st_ff.rx_cnt[$past(req_ch)] == $past(cur_rx_cnt) - 7'h02;
  endproperty
  a_stat_pop2: assert property (p_stat_pop2) else $error("status read did not pop two");

  // a full dword write of the plain window pushes four bytes
  property p_plain_push4;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && host_req.write && req_kind == WIN_PLAIN && host_req.be == 4'hf
       && cur_tx_cnt <= 7'h3c && !cur_tx_pop)
      |=> st_ff.tx_cnt[$past(req_ch)] == $past(cur_tx_cnt) + 7'h04;
  endproperty
  a_plain_push4: assert property (p_plain_push4) else $error("plain write did not push four");

  // lane 0 of a plain read is the byte at the head of the fifo
  property p_lane0_oldest;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && !host_req.write && req_kind == WIN_PLAIN && host_req.be[0]
       && cur_rx_cnt != '0)
      |=> host_rsp.rdata[7:0] == $past(cur_rx_head[7:0]);
  endproperty
  a_lane0_oldest: assert property (p_lane0_oldest) else $error("lane 0 not oldest byte");

  // status half pairs the head byte with its own line status
  property p_stat_pair;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && !host_req.write && req_kind == WIN_STAT && host_req.be[1:0] == 2'h3
       && cur_rx_cnt != '0)
      |=> host_rsp.rdata[15:0] == {$past(cur_rx_head[7:0]), $past(cur_rx_head[15:8])};
  endproperty
  a_stat_pair: assert property (p_stat_pair) else $error("status pair mismatched");

  // legacy read returns the head byte of the addressed channel
  property p_legacy_read;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && !host_req.write && req_kind == WIN_LEGACY && host_req.be == LEGACY_BE
       && cur_rx_cnt != '0)
      |=> !host_rsp.err && host_rsp.rdata[7:0] == $past(cur_rx_head[7:0]);
  endproperty
  a_legacy_read: assert property (p_legacy_read) else $error("legacy read wrong byte");

  // a write to the status window is refused and leaves the tx fifo alone
  property p_stat_write;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && host_req.write && req_kind == WIN_STAT && !cur_tx_pop)
      |=> host_rsp.err && st_ff.tx_cnt[$past(req_ch)] == $past(cur_tx_cnt);
  endproperty
  a_stat_write: assert property (p_stat_write) else $error("status window write taken");

  // a two-lane write of the plain window pushes exactly two bytes
  property p_plain_push2;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && host_req.write && req_kind == WIN_PLAIN && host_req.be == 4'h3
       && cur_tx_cnt <= 7'h3e && !cur_tx_pop)
      |=> st_ff.tx_cnt[$past(req_ch)] == $past(cur_tx_cnt) + 7'h02;
  endproperty
  a_plain_push2: assert property (p_plain_push2) else $error("half write not two");

  // the upper half of a status dword holds the second oldest entry
  property p_stat_hi;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && !host_req.write && req_kind == WIN_STAT && host_req.be == 4'hf
       && cur_rx_cnt >= 7'h02)
      |=> host_rsp.rdata[31:16] == {$past(cur_rx_next[7:0]), $past(cur_rx_next[15:8])};
  endproperty
  a_stat_hi: assert property (p_stat_hi) else $error("upper status half wrong");

  // a transmitter pull from a non-empty fifo gets its byte the next cycle
  property p_tx_deliver;
    @(posedge clock) disable iff (!rst_n)
      (cur_tx_pop && cur_tx_cnt != '0 && !host_req.valid)
      |=> tx_out[$past(req_ch)].vld && tx_level[$past(req_ch)] == $past(cur_tx_cnt) - CNT_ONE;
  endproperty
  a_tx_deliver: assert property (p_tx_deliver) else $error("tx pull not answered");

  // a byte write to a legacy holding register pushes one byte
  property p_legacy_push;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && host_req.write && req_kind == WIN_LEGACY && host_req.be == LEGACY_BE
       && cur_tx_cnt < CNT_FULL && !cur_tx_pop)
      |=> !host_rsp.err && st_ff.tx_cnt[$past(req_ch)] == $past(cur_tx_cnt) + CNT_ONE;
  endproperty
  a_legacy_push: assert property (p_legacy_push) else $error("legacy write not taken");

  // a legacy byte read pops exactly one entry
  property p_legacy_pop;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && !host_req.write && req_kind == WIN_LEGACY && host_req.be == LEGACY_BE
       && cur_rx_cnt != '0 && !cur_rx_push)
      |=> st_ff.rx_cnt[$past(req_ch)] == $past(cur_rx_cnt) - CNT_ONE;
  endproperty
  a_legacy_pop: assert property (p_legacy_pop) else $error("legacy read did not pop one");

  // a plain read of an empty fifo answers zero lanes and no error
  property p_empty_read;
    @(posedge clock) disable iff (!rst_n)
      (host_req.valid && !host_req.write && req_kind == WIN_PLAIN && cur_rx_cnt == '0)
      |=> !host_rsp.err && host_rsp.rdata == '0;
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty read not zero");

  // an answer stands one cycle and only follows a request
  property p_rsp_quiet;
    @(posedge clock) disable iff (!rst_n)
      !host_req.valid |=> !host_rsp.valid;
  endproperty
  a_rsp_quiet: assert property (p_rsp_quiet) else $error("answer without request");

endmodule : bfd_data_window

// *** bfd_chan_model.sv ***
// channel-side model: receivers push bytes, transmitters pop them
`timescale 1ns/1ps
module bfd_chan_model
  import bfd_pkg::*;
(
  input  wire logic                                  clock,
  output bfd_pkg::bfd_rx_in_t [bfd_pkg::NUM_CH-1:0]  rx_in,
  output logic [bfd_pkg::NUM_CH-1:0]                 tx_pop_req,
  input  wire bfd_pkg::bfd_tx_out_t [bfd_pkg::NUM_CH-1:0] tx_out
);
  initial begin
    rx_in      = '0;
    tx_pop_req = '0;
  end

  // one received byte with its line status, pushed as a single entry
  task push_byte(input int c, input logic [7:0] d, input logic [7:0] s);
    @(posedge clock);
    #2;
    rx_in[c] = '{1'b1, s, d};
    @(posedge clock);
    #2;
    rx_in[c].push = 1'b0;
    // idle lines flip so a stale byte is never mistaken for a fresh one
    rx_in[c].data             = ~d;
    rx_in[c].line_status_byte = ~s;
  endtask : push_byte

  // transmitter asks for one byte; answer is sampled after the next edge
  task pop_byte(input int c, output logic vld, output logic [7:0] d);
    @(posedge clock);
    #2;
    tx_pop_req[c] = 1'b1;
    @(posedge clock);
    #2;
    tx_pop_req[c] = 1'b0;
    vld = tx_out[c].vld;
    d   = tx_out[c].data;
  endtask : pop_byte
endmodule : bfd_chan_model

// *** testbench.sv ***
// self-checking bench for the burst fifo data window
`timescale 1ns/1ps
module testbench;
  import bfd_pkg::*;
  logic                         clock;
  logic                         rst_n;
  bfd_req_t                     req;
  bfd_rsp_t                     rsp;
  bfd_rx_in_t [NUM_CH-1:0]      rx_in;
  logic [NUM_CH-1:0]            tx_pop_req;
  bfd_tx_out_t [NUM_CH-1:0]     tx_out;
  logic [NUM_CH-1:0][CNT_W-1:0] rx_level;
  logic [NUM_CH-1:0][CNT_W-1:0] tx_level;
  int                           error_cnt;
  int                           cmp_count;

  bfd_data_window DUT (.clock(clock), .rst_n(rst_n), .host_req(req), .host_rsp(rsp),
    .rx_in(rx_in), .tx_pop_req(tx_pop_req), .tx_out(tx_out),
    .rx_level(rx_level), .tx_level(tx_level));
  bfd_chan_model chan (.clock(clock), .rx_in(rx_in), .tx_pop_req(tx_pop_req),
    .tx_out(tx_out));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task end_of_test;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one host request; answer taken 2 ns after the edge that takes it
  task host(input logic wr, input logic [11:0] a, input logic [3:0] be,
            input logic [31:0] wd, input logic e_err, input logic [31:0] e_dat);
    @(posedge clock);
    #2;
    req = '{1'b1, wr, a, be, wd};
    @(posedge clock);
    #2;
    req.valid = 1'b0;
    chk("rsp valid", 32'h1, {31'h0, rsp.valid});
    chk("rsp err", {31'h0, e_err}, {31'h0, rsp.err});
    if (!e_err) chk("rsp rdata", e_dat, rsp.rdata);
  endtask : host

  // fill channel 2 to the brim, drain it in 16 dword reads
  task t_plain_burst;
    for (int i = 0; i < 64; i++) chan.push_byte(2, 8'h10 + i[7:0], 8'h00);
    chk("rx level ch2 full", 32'h40, {25'h0, rx_level[2]});
    for (int k = 0; k < 16; k++) begin
      host(1'b0, 12'h500 + 12'(4 * k), 4'hf, 32'h0, 1'b0,
           {8'h13, 8'h12, 8'h11, 8'h10} + {4{8'(4 * k)}});
    end
    chk("rx level ch2 empty", 32'h0, {25'h0, rx_level[2]});
    host(1'b0, 12'h500, 4'hf, 32'h0, 1'b0, 32'h0);
  endtask : t_plain_burst

  // status window pairs each byte with its line status byte
  task t_status;
    chan.push_byte(0, 8'ha5, 8'h01);
    chan.push_byte(0, 8'h5a, 8'h1e);
    host(1'b0, 12'h180, 4'hf, 32'h0, 1'b0, 32'h5a1ea501);
    chk("rx level ch0", 32'h0, {25'h0, rx_level[0]});
    host(1'b1, 12'h184, 4'hf, 32'h0, 1'b1, 32'h0);
  endtask : t_status

  // full and partial dword writes, drained in order by the transmitter
  task t_tx_write;
    logic       v;
    logic [7:0] d;
    host(1'b1, 12'hf3c, 4'hf, 32'h44332211, 1'b0, 32'h0);
    host(1'b1, 12'hf00, 4'h3, 32'h99886655, 1'b0, 32'h0);
    chk("tx level ch7", 32'h6, {25'h0, tx_level[7]});
    for (int i = 1; i <= 6; i++) begin
      chan.pop_byte(7, v, d);
      chk("tx byte ch7", {23'h0, 1'b1, 8'(i * 8'h11)}, {23'h0, v, d});
    end
    chan.pop_byte(7, v, d);
    chk("tx empty vld", 32'h0, {31'h0, v});
  endtask : t_tx_write

  // legacy byte registers: byte access only, one per channel block
  task t_legacy;
    logic       v;
    logic [7:0] d;
    chan.push_byte(1, 8'hc3, 8'h60);
    host(1'b0, 12'h200, 4'hf, 32'h0, 1'b1, 32'h0);
    host(1'b0, 12'h200, 4'h1, 32'h0, 1'b0, 32'h000000c3);
    host(1'b1, 12'ha00, 4'h1, 32'h0000007e, 1'b0, 32'h0);
    chan.pop_byte(5, v, d);
    chk("legacy tx ch5", 32'h17e, {23'h0, v, d});
  endtask : t_legacy

  // reserved holes answer with an error and move nothing
  task t_reserved;
    host(1'b0, 12'h140, 4'hf, 32'h0, 1'b1, 32'h0);
    host(1'b1, 12'h604, 4'hf, 32'h0, 1'b1, 32'h0);
    chk("tx level ch3", 32'h0, {25'h0, tx_level[3]});
  endtask : t_reserved

  // bounded run: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    rst_n     = 1'b0;
    req       = '0;
    repeat (6) @(posedge clock);
    #2;
    rst_n = 1'b1;
    t_plain_burst();
    t_status();
    t_tx_write();
    t_legacy();
    t_reserved();
    end_of_test();
  end
endmodule : testbench
